/* File: mob_pkg.sv */
// constants, register map and types for the muting override block
package mob_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS   = 5;
    localparam int unsigned SECOND_NS       = 1000000000;
    localparam int unsigned SEC_CYCLES_DFLT = SECOND_NS / CLK_PERIOD_NS;
    localparam int unsigned PRE_W           = 28;
    localparam int unsigned SEC_W           = 16;
    localparam logic [SEC_W-1:0] TMO_MIN_SEC     = 16'h000a;
    localparam logic [SEC_W-1:0] TMO_UNLIMITED   = 16'h0000;
    localparam logic [SEC_W-1:0] TMO_RESET_VALUE = 16'h000a;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_CTRL    = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] OFS_TIMEOUT = 32'h0000_0004;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 32'h0000_0008;

    // ctrl fields
    localparam int unsigned CTRL_W          = 5;
    localparam int unsigned CTRL_PULSED     = 0;
    localparam int unsigned CTRL_OCC_SENSOR = 1;
    localparam int unsigned CTRL_ACTIVE_SIG = 2;
    localparam int unsigned CTRL_REQ_SIG    = 3;
    localparam int unsigned CTRL_RST_MON    = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET_VALUE = 5'h00;

    // status fields
    localparam int unsigned STAT_ACTIVE    = 0;
    localparam int unsigned STAT_POSSIBLE  = 1;
    localparam int unsigned STAT_OUTPUT    = 2;
    localparam int unsigned STAT_RESET_OK  = 3;
    localparam int unsigned STAT_EXPIRED   = 4;
    localparam int unsigned STAT_PINS_LSB  = 8;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic muting;
        logic sensor_occ;
        logic curtain_occ;
        logic req;
        logic rst_cmd;
    } mob_pins_t;

    localparam int unsigned PINS_W = $bits(mob_pins_t);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACTIVE,
        ST_WAIT_REL
    } mob_state_t;

endpackage

/* File: mob_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module mob_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] ff1_q;
    logic [WIDTH-1:0] ff2_q;
    logic [WIDTH-1:0] ff3_q;
    logic [WIDTH-1:0] agree;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ff1_q <= '0;
            ff2_q <= '0;
            ff3_q <= '0;
        end else begin
            ff1_q <= d_in;
            ff2_q <= ff1_q;
            ff3_q <= ff2_q;
        end
    end

    assign agree = ~(ff2_q ^ ff3_q);

    // a bit changes only once stages two and three agree
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            q_out <= '0;
        end else begin
            q_out <= (q_out & ~agree) | (ff3_q & agree);
        end
    end
endmodule

/* File: mob_timer.sv */
// seconds timer for the override timeout
`timescale 1ns/1ps
module mob_timer
    import mob_pkg::*;
#(
    parameter logic [PRE_W-1:0] SEC_LAST = PRE_W'(SEC_CYCLES_DFLT - 1)
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_in,
    input  wire logic             run_in,
    input  wire logic [SEC_W-1:0] limit_sec_in,
    output logic                  expired_out
);
    logic [PRE_W-1:0] pre_q;
    logic [SEC_W-1:0] sec_q;

    // restarts from zero whenever run drops
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            pre_q <= '0;
            sec_q <= '0;
        end else if (!run_in) begin
            pre_q <= '0;
            sec_q <= '0;
        end else if (pre_q == SEC_LAST) begin
            pre_q <= '0;
            if (sec_q != {SEC_W{1'b1}}) begin
                sec_q <= sec_q + 16'h0001;
            end
        end else begin
            pre_q <= pre_q + 28'h0000001;
        end
    end

    // zero limit means no timeout at all
    assign expired_out = run_in && (limit_sec_in != TMO_UNLIMITED)
                         && (sec_q >= limit_sec_in);
endmodule

/* File: mob_override.sv */
// muting override block with apb register access
`timescale 1ns/1ps
module mob_override #(
    parameter int unsigned SEC_CYCLES = mob_pkg::SEC_CYCLES_DFLT
) (
    input  wire logic                       core_clk_in,
    input  wire logic                       rst_in,
    input  wire logic                       psel_in,
    input  wire logic                       penable_in,
    input  wire logic                       pwrite_in,
    input  wire logic [mob_pkg::ADDR_W-1:0] paddr_in,
    input  wire logic [mob_pkg::DATA_W-1:0] pwdata_in,
    output logic      [mob_pkg::DATA_W-1:0] prdata_out,
    output logic                            pready_out,
    output logic                            pslverr_out,
    input  wire logic                       muting_in,
    input  wire logic                       sensor_occupied_in,
    input  wire logic                       curtain_occupied_in,
    input  wire logic                       override_req_in,
    input  wire logic                       reset_cmd_in,
    output logic                            safety_switching_output_out,
    output logic                            bypass_active_flag_out,
    output logic                            request_possible_out
);
    import mob_pkg::*;

    // ------------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------------
    mob_pins_t pins_raw;
    mob_pins_t pins_s;
    logic      req_prev_q;
    logic      rst_prev_q;

    assign pins_raw = {muting_in, sensor_occupied_in, curtain_occupied_in,
                       override_req_in, reset_cmd_in};

    mob_sync #(
        .WIDTH (PINS_W)
    ) u_sync (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .d_in        (pins_raw),
        .q_out       (pins_s)
    );

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            req_prev_q <= 1'b0;
            rst_prev_q <= 1'b0;
        end else begin
            req_prev_q <= pins_s.req;
            rst_prev_q <= pins_s.rst_cmd;
        end
    end

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_q;
    logic [SEC_W-1:0]  timeout_q;
    logic              pready_q;
    logic              pslverr_q;
    logic [DATA_W-1:0] prdata_q;
    logic              setup;
    logic              wr_take;
    logic              addr_hit;
    logic [DATA_W-1:0] rd_mux;
    logic [SEC_W-1:0]  tmo_wr;
    logic [DATA_W-1:0] status_word;

    assign setup    = psel_in && !penable_in;
    assign wr_take  = psel_in && penable_in && pready_q && pwrite_in
                      && !pslverr_q;
    assign addr_hit = (paddr_in == OFS_CTRL) || (paddr_in == OFS_TIMEOUT)
                      || (paddr_in == OFS_STATUS);

    always_comb begin
        rd_mux = '0;
        case (paddr_in)
            OFS_CTRL:    rd_mux = {{(DATA_W-CTRL_W){1'b0}}, ctrl_q};
            OFS_TIMEOUT: rd_mux = {{(DATA_W-SEC_W){1'b0}}, timeout_q};
            OFS_STATUS:  rd_mux = status_word;
            default:     rd_mux = '0;
        endcase
    end

    // answer in the first access cycle
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !addr_hit;
            prdata_q  <= (setup && !pwrite_in) ? rd_mux : '0;
        end
    end

    // short timeouts are raised to the minimum
    always_comb begin
        tmo_wr = pwdata_in[SEC_W-1:0];
        if (tmo_wr != TMO_UNLIMITED && tmo_wr < TMO_MIN_SEC) begin
            tmo_wr = TMO_MIN_SEC;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ctrl_q    <= CTRL_RESET_VALUE;
            timeout_q <= TMO_RESET_VALUE;
        end else if (wr_take) begin
            if (paddr_in == OFS_CTRL) begin
                ctrl_q <= pwdata_in[CTRL_W-1:0];
            end
            if (paddr_in == OFS_TIMEOUT) begin
                timeout_q <= tmo_wr;
            end
        end
    end

    assign prdata_out  = prdata_q;
    assign pready_out  = pready_q;
    assign pslverr_out = pslverr_q;

    // ------------------------------------------------------------------
    // override qualification and state machine
    // ------------------------------------------------------------------
    logic       pulsed;
    logic       opt_occ;
    logic       rst_mon;
    logic       muting;
    logic       req;
    logic       req_rise;
    logic       gap_free;
    logic       qualify;
    logic       start;
    logic       expired;
    logic       active;
    mob_state_t state_q;

    assign pulsed   = ctrl_q[CTRL_PULSED];
    assign opt_occ  = ctrl_q[CTRL_OCC_SENSOR];
    assign rst_mon  = ctrl_q[CTRL_RST_MON];
    assign muting   = pins_s.muting;
    assign req      = pins_s.req;
    assign req_rise = req && !req_prev_q;
    assign gap_free = !pins_s.sensor_occ && !pins_s.curtain_occ;
    assign active   = (state_q == ST_ACTIVE);

    // sensor option narrows the occupancy condition
    assign qualify = !muting && (opt_occ ? pins_s.sensor_occ
                     : (pins_s.sensor_occ || pins_s.curtain_occ));
    assign start   = qualify && (pulsed ? req_rise : req);

    mob_timer #(
        .SEC_LAST (PRE_W'(SEC_CYCLES - 1))
    ) u_timer (
        .core_clk_in  (core_clk_in),
        .rst_in       (rst_in),
        .run_in       (active),
        .limit_sec_in (timeout_q),
        .expired_out  (expired)
    );

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (gap_free || expired
                        || (!pulsed && !req)) begin
                        state_q <= req ? ST_WAIT_REL : ST_IDLE;
                    end
                end
                ST_WAIT_REL: begin
                    if (!req) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // reset recognition
    // ------------------------------------------------------------------
    logic rst_rise;
    logic rst_fall;
    logic rst_accept;
    logic rst_armed_q;
    logic reset_ok_q;

    assign rst_rise   = pins_s.rst_cmd && !rst_prev_q;
    assign rst_fall   = !pins_s.rst_cmd && rst_prev_q;
    assign rst_accept = rst_mon ? (rst_armed_q && rst_fall)
                                : rst_rise;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rst_armed_q <= 1'b0;
        end else if (!rst_mon || rst_fall) begin
            rst_armed_q <= 1'b0;
        end else if (rst_rise) begin
            rst_armed_q <= 1'b1;
        end
    end

    // cleared whenever muting drops, so each muted phase needs a reset
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            reset_ok_q <= 1'b0;
        end else if (!muting) begin
            reset_ok_q <= 1'b0;
        end else if (rst_accept) begin
            reset_ok_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    logic out_q;
    logic flag_q;
    logic possible_q;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            out_q      <= 1'b0;
            flag_q     <= 1'b0;
            possible_q <= 1'b0;
        end else begin
            out_q      <= muting ? reset_ok_q
                                 : active;
            flag_q     <= active && ctrl_q[CTRL_ACTIVE_SIG];
            possible_q <= qualify && ctrl_q[CTRL_REQ_SIG];
        end
    end

    assign safety_switching_output_out = out_q;
    assign bypass_active_flag_out      = flag_q;
    assign request_possible_out        = possible_q;

    always_comb begin
        status_word                = '0;
        status_word[STAT_ACTIVE]   = active;
        status_word[STAT_POSSIBLE] = qualify;
        status_word[STAT_OUTPUT]   = out_q;
        status_word[STAT_RESET_OK] = reset_ok_q;
        status_word[STAT_EXPIRED]  = expired;
        status_word[STAT_PINS_LSB +: PINS_W] = pins_s;
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_pulsed_edge;
        pulsed && !req && state_q == ST_IDLE
        ##1 pulsed && req && qualify && state_q == ST_IDLE;
    endsequence

    sequence s_monitored_pulse;
        rst_mon && muting && rst_armed_q && !pins_s.rst_cmd && rst_prev_q;
    endsequence

    AST_START_QUAL: assert property (
        $rose(active) |-> $past(qualify))
        else $error("override started without qualifying condition");
    AST_MAINT_DROP: assert property (
        (active && !pulsed && !req) |=> !active)
        else $error("maintained override kept after request drop");
    AST_GAP_FREE: assert property (
        (active && gap_free) |=> !active)
        else $error("override kept with gap free");
    AST_PULSE_START: assert property (
        s_pulsed_edge |=> active)
        else $error("pulsed request edge did not start override");
    AST_NO_RESTART: assert property (
        (state_q == ST_WAIT_REL) |=> !active)
        else $error("override restarted without new request");
    AST_TIMEOUT: assert property (
        (active && expired) |=> !active)
        else $error("override kept after timeout");
    AST_UNLIMITED: assert property (
        (timeout_q == TMO_UNLIMITED) |-> !expired)
        else $error("timeout expired while unlimited");
    AST_FLAG: assert property (
        (active && ctrl_q[CTRL_ACTIVE_SIG]) ##1 active |-> ##1 flag_q)
        else $error("active flag missing during override");
    AST_POSSIBLE: assert property (
        request_possible_out |-> $past(qualify))
        else $error("request possible shown without condition");
    AST_MUTED_OUT: assert property (
        (muting && !reset_ok_q) |=> !safety_switching_output_out)
        else $error("output enabled under muting without reset");
    AST_TRACK: assert property (
        !muting |=> (safety_switching_output_out == $past(active)))
        else $error("output does not follow override while unmuted");
    AST_MON_RESET: assert property (
        s_monitored_pulse |=> reset_ok_q ##1 safety_switching_output_out
                              || !muting)
        else $error("monitored reset pulse not accepted");
    AST_POSS_ON: assert property (
        (qualify && ctrl_q[CTRL_REQ_SIG]) |=> request_possible_out)
        else $error("request possible missing with condition met");
    AST_TMR_FRESH: assert property (
        $rose(active) |-> !expired)
        else $error("timeout counter not cleared at override start");
endmodule

/* File: mob_far_model.sv */
// far-side model: upstream muting result and operator pins
`timescale 1ns/1ps
module mob_far_model (
    input  wire logic               core_clk_in,
    input  wire logic               slow_in,
    input  wire mob_pkg::mob_pins_t cmd_in,
    output logic                    muting_out,
    output logic                    sensor_out,
    output logic                    curtain_out,
    output logic                    req_out,
    output logic                    rst_cmd_out
);
    import mob_pkg::*;

    mob_pins_t stage_q;
    mob_pins_t pins_q;

    // ------------------------------------------------------------
    // pins move just after an edge; slow adds one cycle of lag
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        stage_q <= cmd_in;
        pins_q  <= slow_in ? stage_q : cmd_in;
    end

    assign muting_out  = pins_q.muting;
    assign sensor_out  = pins_q.sensor_occ;
    assign curtain_out = pins_q.curtain_occ;
    assign req_out     = pins_q.req;
    assign rst_cmd_out = pins_q.rst_cmd;
endmodule

/* File: mob_override_tb_top.sv */
// self-checking bench for the muting override block
`timescale 1ns/1ps
module mob_override_tb_top;
    import mob_pkg::*;

    localparam logic [4:0] P_MUT = 5'h10;
    localparam logic [4:0] P_SEN = 5'h08;
    localparam logic [4:0] P_CUR = 5'h04;
    localparam logic [4:0] P_REQ = 5'h02;
    localparam logic [4:0] P_RST = 5'h01;

    logic        core_clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        muting, sensor, curtain, req, rst_cmd;
    logic        safety, flag, possible, slow;
    mob_pins_t   cmd;
    logic [31:0] rd;
    logic        err;
    int          n_fail;
    int          check_count;

    mob_override #(.SEC_CYCLES(4)) dut (
        .core_clk_in                 (core_clk),
        .rst_in                      (rst),
        .psel_in                     (psel),
        .penable_in                  (penable),
        .pwrite_in                   (pwrite),
        .paddr_in                    (paddr),
        .pwdata_in                   (pwdata),
        .prdata_out                  (prdata),
        .pready_out                  (pready),
        .pslverr_out                 (pslverr),
        .muting_in                   (muting),
        .sensor_occupied_in          (sensor),
        .curtain_occupied_in         (curtain),
        .override_req_in             (req),
        .reset_cmd_in                (rst_cmd),
        .safety_switching_output_out (safety),
        .bypass_active_flag_out      (flag),
        .request_possible_out        (possible)
    );

    mob_far_model far (
        .core_clk_in (core_clk),
        .slow_in     (slow),
        .cmd_in      (cmd),
        .muting_out  (muting),
        .sensor_out  (sensor),
        .curtain_out (curtain),
        .req_out     (req),
        .rst_cmd_out (rst_cmd)
    );

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic sig(input int s);
        return (s == 0) ? safety : (s == 1) ? flag : possible;
    endfunction

    task automatic wt(input string nm, input int s, input logic v,
                      input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge core_clk);
            if (sig(s) === v) break;
        end
        chk(nm, {31'h0, v}, {31'h0, sig(s)});
        if (i == lim) test_done;
    endtask

    task automatic hd(input string nm, input int s, input logic v,
                      input int n);
        int bad;
        bad = 0;
        repeat (n) begin
            @(posedge core_clk);
            if (sig(s) !== v) bad++;
        end
        chk(nm, 32'h0, 32'(bad));
    endtask

    task automatic apb(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            chk("pready", 32'h1, 32'h0);
            test_done;
        end
    endtask

    task automatic pins(input logic [4:0] v);
        @(posedge core_clk);
        cmd <= mob_pins_t'(v);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b0, OFS_TIMEOUT, 32'h0);
        chk("tmo reset", 32'h0000_000a, rd);
        apb(1'b1, OFS_TIMEOUT, 32'h0000_0003);
        apb(1'b0, OFS_TIMEOUT, 32'h0);
        chk("tmo floor", 32'h0000_000a, rd);
        apb(1'b1, OFS_TIMEOUT, 32'h0001_1234);
        apb(1'b0, OFS_TIMEOUT, 32'h0);
        chk("tmo wide", 32'h0000_1234, rd);
        apb(1'b1, OFS_STATUS, 32'hffff_ffff);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status ro", 32'h0, rd);
        apb(1'b0, 32'h0000_000c, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        $display("test regs done");
    endtask

    task automatic t_maint;
        apb(1'b1, OFS_CTRL, 32'h0000_0004);
        pins(P_CUR | P_REQ);
        wt("maint on", 0, 1'b1, 12);
        wt("flag on", 1, 1'b1, 2);
        pins(P_CUR);
        wt("drop off", 0, 1'b0, 12);
        wt("flag off", 1, 1'b0, 2);
        pins(P_CUR | P_REQ);
        wt("re-raise on", 0, 1'b1, 12);
        pins(P_REQ);
        wt("gap free off", 0, 1'b0, 12);
        pins(P_CUR | P_REQ);
        hd("held no restart", 0, 1'b0, 12);
        pins(5'h00);
        $display("test maint done");
    endtask

    task automatic t_refuse;
        apb(1'b1, OFS_CTRL, 32'h0000_000e);
        pins(P_MUT | P_SEN | P_CUR | P_REQ);
        hd("muted refuse", 0, 1'b0, 12);
        hd("muted possible", 2, 1'b0, 2);
        pins(P_CUR);
        hd("curtain only", 2, 1'b0, 10);
        pins(P_CUR | P_REQ);
        hd("curtain refuse", 0, 1'b0, 12);
        pins(P_SEN | P_CUR);
        wt("possible on", 2, 1'b1, 12);
        pins(P_SEN | P_CUR | P_REQ);
        wt("sensor on", 0, 1'b1, 12);
        wt("flag on", 1, 1'b1, 2);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status active", 32'h0000_0e07, rd);
        pins(P_REQ);
        wt("gap free off", 0, 1'b0, 12);
        pins(5'h00);
        $display("test refuse done");
    endtask

    task automatic t_pulse;
        apb(1'b1, OFS_CTRL, 32'h0000_0005);
        slow <= 1'b1;
        pins(P_CUR | P_REQ);
        wt("pulse on", 0, 1'b1, 14);
        pins(P_CUR);
        hd("pulse stays", 0, 1'b1, 12);
        pins(5'h00);
        wt("pulse gap off", 0, 1'b0, 14);
        pins(P_SEN);
        hd("no restart", 0, 1'b0, 12);
        pins(P_SEN | P_REQ);
        wt("pulse again", 0, 1'b1, 14);
        pins(P_REQ);
        wt("pulse end", 0, 1'b0, 14);
        pins(P_SEN | P_REQ);
        hd("held no restart p", 0, 1'b0, 12);
        pins(5'h00);
        slow <= 1'b0;
        $display("test pulse done");
    endtask

    task automatic t_timeout;
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_TIMEOUT, 32'h0000_000a);
        pins(P_CUR | P_REQ);
        wt("tmo on", 0, 1'b1, 12);
        chk("flag hidden", 32'h0, {31'h0, flag});
        chk("possible hidden", 32'h0, {31'h0, possible});
        hd("tmo early", 0, 1'b1, 38);
        wt("tmo expire", 0, 1'b0, 4);
        apb(1'b1, OFS_TIMEOUT, 32'h0);
        pins(P_CUR);
        hd("after expire", 0, 1'b0, 6);
        pins(P_CUR | P_REQ);
        wt("unlim on", 0, 1'b1, 12);
        hd("unlim stays", 0, 1'b1, 120);
        pins(5'h00);
        wt("unlim off", 0, 1'b0, 12);
        $display("test timeout done");
    endtask

    task automatic t_reset;
        pins(P_MUT | P_SEN);
        hd("muted no reset", 0, 1'b0, 10);
        pins(P_MUT | P_SEN | P_RST);
        wt("manual reset", 0, 1'b1, 12);
        pins(P_SEN);
        wt("unmuted follows", 0, 1'b0, 12);
        apb(1'b1, OFS_CTRL, 32'h0000_0010);
        pins(P_MUT | P_SEN);
        hd("mon idle", 0, 1'b0, 6);
        pins(P_MUT | P_SEN | P_RST);
        hd("mon rise only", 0, 1'b0, 12);
        pins(P_MUT | P_SEN);
        wt("mon fall", 0, 1'b1, 12);
        pins(5'h00);
        wt("mon clear", 0, 1'b0, 12);
        $display("test reset done");
    endtask

    initial begin
        n_fail = 0;
        check_count = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        slow = 1'b0;
        cmd = mob_pins_t'(5'h00);
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_regs;
        t_maint;
        t_refuse;
        t_pulse;
        t_timeout;
        t_reset;
        test_done;
    end
endmodule
